// File: tb/aqs_conv_model.sv
// Model of the two conversion channels and the low-power oscillator
`timescale 1ns/1ps
module aqs_conv_model #(
	parameter int OSC_HALF = 8
)
(
	input wire logic ref_clk_in,
	input wire logic fire_in,
	input wire logic [15:0] cur_val_in,
	input wire logic [15:0] volt_val_in,
	output logic osc_out,
	output logic cur_ready_out,
	output logic volt_ready_out,
	output logic [15:0] cur_sample_out,
	output logic [15:0] volt_sample_out
);
	int cnt = 0;
	initial begin
		osc_out = 0;
		cur_ready_out = 0;
		volt_ready_out = 0;
		cur_sample_out = 0;
		volt_sample_out = 0;
	end
	// Samples flip outside a result so stale data never looks valid
	always @(posedge ref_clk_in) begin
		cnt <= (cnt == OSC_HALF - 1) ? 0 : cnt + 1;
		if (cnt == OSC_HALF - 1) osc_out <= !osc_out;
		cur_ready_out <= fire_in;
		volt_ready_out <= fire_in;
		cur_sample_out <= fire_in ? cur_val_in : ~cur_sample_out;
		volt_sample_out <= fire_in ? volt_val_in : ~volt_sample_out;
	end
endmodule

// File: tb/tb.sv
// Self-checking bench for the acquisition mode sequencer
`timescale 1ns/1ps
module tb;
	import aqs_pkg::*;
	localparam int INIT_N = 20;
	localparam int STAB_N = 30;
	logic ref_clk_in = 0;
	logic rst_in = 1;
	logic digital_power_on_detect = 0;
	logic analog_power_on_detect = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] addr = 0;
	logic [7:0] wdata = 0;
	logic fire = 0;
	logic [15:0] cval = 0;
	logic [15:0] vval = 0;
	logic osc, cur_rdy, volt_rdy, int_out, dp_en, meas_rst;
	logic [15:0] cur_s, volt_s, cur_data, volt_data, last;
	logic [7:0] rdata, rv, ex;
	logic [2:0] clk_cfg;
	logic [7:0] ra[6] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
	logic [7:0] re[6] = '{PERIOD_RESET[7:0], PERIOD_RESET[15:8], THRESH_RESET[7:0],
		THRESH_RESET[15:8], RELAX_RESET[7:0], RELAX_RESET[15:8]};
	int failures = 0;
	int checked = 0;
	int init_n = 0;
	int meas_n = 0;
	int m, n, k;
	bit armed = 0;
	bit osc_q;
	logic [15:0] q[$];
	logic [31:0] seed = 32'hc13016bf;
	always #10 ref_clk_in = ~ref_clk_in;
	aqs_conv_model aqs_conv_model_i (.ref_clk_in(ref_clk_in), .fire_in(fire),
		.cur_val_in(cval), .volt_val_in(vval), .osc_out(osc), .cur_ready_out(cur_rdy),
		.volt_ready_out(volt_rdy), .cur_sample_out(cur_s), .volt_sample_out(volt_s));
	aqs_adc_mode_sequencer #(.INIT_CYCLES(TMR_W'(INIT_N)), .STAB_CYCLES(TMR_W'(STAB_N)))
	aqs_adc_mode_sequencer_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.digital_power_on_detect_in(digital_power_on_detect), .analog_power_on_detect_in(analog_power_on_detect),
		.low_power_osc_clock_in(osc), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .cur_ready_in(cur_rdy),
		.volt_ready_in(volt_rdy), .cur_sample_in(cur_s), .volt_sample_in(volt_s),
		.reg_rdata_out(rdata), .int_out(int_out), .datapath_enable_out(dp_en),
		.meas_path_reset_out(meas_rst), .clk_config_out(clk_cfg),
		.cur_data_out(cur_data), .volt_data_out(volt_data));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1;
		addr = a;
		wdata = d;
		tick(1);
		reg_wr = 0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_rd = 1;
		addr = a;
		tick(1);
		reg_rd = 0;
		rv = rdata;
		tick(1);
	endtask
	// Results start just after an oscillator falling edge to keep edge counts clean
	task automatic shot(input logic [15:0] c, input bit push);
		@(negedge osc);
		tick(1);
		seed = lfsr(seed);
		vval = seed[15:0];
		cval = c;
		fire = 1;
		if (push) q.push_back(c);
		tick(1);
		fire = 0;
		// Let the result reach the sequencer before anyone polls its outputs
		tick(1);
	endtask
	task automatic wait_low();
		for (k = 0; k < 2000 && int_out !== 1'b0; k++) tick(1);
		chk("int_low", 16'(k < 2000), 1);
	endtask
	task automatic wait_dp();
		for (k = 0; k < 1000 && dp_en !== 1'b1; k++) tick(1);
		chk("wake", 16'(k < 1000), 1);
	endtask
	task automatic take();
		if (q.size() == 0) chk("extra_int", 1, 0);
		else chk("cur_data", cur_data, q.pop_front());
		last = cur_data;
	endtask
	always @(posedge ref_clk_in) if (meas_rst === 1'b1) meas_n++;
	always @(posedge int_out) begin
		#1;
		if (!armed) init_n++;
		else begin
			n = 0;
			osc_q = osc;
			take();
			for (int j = 0; j < 3000 && int_out === 1'b1; j++) begin
				@(posedge ref_clk_in);
				#2;
				if (osc && !osc_q) n++;
				osc_q = osc;
				if (int_out === 1'b1 && cur_data !== last) begin
					take();
					n = 0;
				end
			end
			chk("int_len", 16'(n), 8);
		end
	end
	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		failures++;
		stop_test();
	end
	initial begin
		tick(12);
		rst_in = 0;
		wr(ADDR_MODE, 8'h01);
		digital_power_on_detect = 1;
		analog_power_on_detect = 1;
		tick(INIT_N + 10);
		armed = 1;
		rd(ADDR_MODE);
		chk("mode", rv, MODE_RESET);
		chk("dp_en", dp_en, 0);
		rd(ADDR_SOFT_RESET);
		chk("soft_rst", rv, SOFT_RESET_READ);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i]);
			chk("reg_rst", rv, re[i]);
		end
		rd(8'h03);
		chk("unmapped", rv, 0);
		ex = 0;
		for (int v = 0; v < 8; v++) begin
			wr(ADDR_CLK_CFG, 8'(v));
			if (v == 0 || v == 1 || v == 3 || v == 5) ex = 8'(v);
			chk("clk_cfg", clk_cfg, ex);
		end
		wr(ADDR_MODE, 8'h01);
		chk("dp_en", dp_en, 1);
		tick(STAB_N + 4);
		wr(ADDR_MODE, 8'h81);
		rd(ADDR_MODE);
		chk("mode", rv, 8'h01);
		m = meas_n;
		wr(ADDR_SOFT_RESET, 8'h80);
		wr(ADDR_SOFT_RESET, 8'h7f);
		chk("meas_rst", 16'(meas_n - m), 0);
		rd(ADDR_MODE);
		chk("mode", rv, 8'h01);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			shot(seed[31:16], 1);
			wait_low();
			chk("volt_data", volt_data, vval);
		end
		rd(ADDR_STATUS);
		chk("status", rv, 8'h03);
		rd(ADDR_STATUS);
		chk("status", rv, 8'h00);
		wr(ADDR_MODE, 8'h00);
		chk("dp_en", dp_en, 0);
		last = cur_data;
		shot(16'h1234, 0);
		tick(3);
		chk("held", cur_data, last);
		wr(ADDR_PERIOD_LO, 8'h20);
		wr(ADDR_PERIOD_HI, 8'h00);
		wr(ADDR_MODE, 8'h81);
		tick(STAB_N + 4);
		shot(16'h0a11, 1);
		shot(16'h0a22, 0);
		wait_low();
		chk("dp_en", dp_en, 0);
		m = meas_n;
		wr(ADDR_SOFT_RESET, 8'h80);
		chk("meas_rst", 16'(meas_n - m), 1);
		shot(16'h0a33, 0);
		wait_dp();
		shot(16'h0a44, 1);
		wait_low();
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_THRESH_LO, 8'h00);
		wr(ADDR_THRESH_HI, 8'h10);
		wr(ADDR_MODE, 8'hc1);
		tick(STAB_N + 4);
		shot(16'h0800, 0);
		wait_dp();
		shot(16'he000, 1);
		wait_low();
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_RELAX_LO, 8'h10);
		wr(ADDR_RELAX_HI, 8'h00);
		wr(ADDR_MODE, 8'h41);
		tick(STAB_N + 640);
		shot(16'h0100, 1);
		shot(16'h0200, 0);
		wait_low();
		tick(320);
		shot(16'h3000, 1);
		wait_low();
		shot(16'h3100, 1);
		shot(16'h3200, 1);
		wait_low();
		wr(ADDR_MODE, 8'h00);
		armed = 0;
		init_n = 0;
		wr(ADDR_SOFT_RESET, 8'h7f);
		tick(INIT_N + 10);
		chk("init_int", 16'(init_n > 0), 1);
		armed = 1;
		rd(ADDR_RELAX_LO);
		chk("relax", rv, RELAX_RESET[7:0]);
		armed = 0;
		wr(ADDR_MODE, 8'h01);
		tick(5);
		analog_power_on_detect = 0;
		tick(4);
		chk("dp_en", dp_en, 0);
		analog_power_on_detect = 1;
		tick(INIT_N + 10);
		chk("queue", 16'(q.size()), 0);
		stop_test();
	end
endmodule

// File: verilog/aqs_adc_mode_sequencer.sv
// Mode sequencer for the dual-channel acquisition die
`timescale 1ns/1ps
module aqs_adc_mode_sequencer
	import aqs_pkg::*;
#(
	parameter logic [TMR_W-1:0] INIT_CYCLES = TMR_W'(INIT_CYC),
	parameter logic [TMR_W-1:0] STAB_CYCLES = TMR_W'(STAB_CYC)
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic digital_power_on_detect_in,
	input wire logic analog_power_on_detect_in,
	input wire logic low_power_osc_clock_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic cur_ready_in,
	input wire logic volt_ready_in,
	input wire logic [15:0] cur_sample_in,
	input wire logic [15:0] volt_sample_in,
	output logic [7:0] reg_rdata_out,
	output logic int_out,
	output logic datapath_enable_out,
	output logic meas_path_reset_out,
	output logic [2:0] clk_config_out,
	output logic [15:0] cur_data_out,
	output logic [15:0] volt_data_out
);
	aqs_state_type state;
	aqs_state_type next_state;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic lp_prev;
	logic [7:0] mode_control;
	logic [15:0] standby_period;
	logic [15:0] current_threshold;
	logic [15:0] relaxed_period;
	logic [1:0] status;
	logic [1:0] target_sel;
	logic fast_rate;
	logic relax_due;
	logic [3:0] int_cnt;
	logic cyc_exp;
	logic per_exp;

	// Pins from other domains pass two flops first
	wire [2:0] pins = {low_power_osc_clock_in, analog_power_on_detect_in,
		digital_power_on_detect_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pins[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate
	wire digital_power_on_detect_ok = sync2[0];
	wire analog_power_on_detect_ok = sync2[1];
	wire lp_level = sync2[2];
	wire lp_tick = lp_level && !lp_prev;

	// Decodes
	wire in_stop = (state == ST_STOP);
	wire in_mode = (state == ST_NORMAL_FULL_RATE_MODE) || (state == ST_NORMAL_THRESHOLD_RATE_MODE) ||
		(state == ST_SBM_ON) || (state == ST_SBM_OFF) || (state == ST_STAB);
	wire wr_mode = reg_wr_in && (reg_addr_in == ADDR_MODE);
	wire wr_rst = reg_wr_in && (reg_addr_in == ADDR_SOFT_RESET);
	wire [1:0] wr_sel = {reg_wdata_in[SEL_HI], reg_wdata_in[SEL_LO]};
	wire start_req = wr_mode && reg_wdata_in[START_BIT] && in_stop; // [RULE2] [RULE10]
	wire stop_req = wr_mode && !reg_wdata_in[START_BIT] && in_mode;
	wire dev_rst_ok = in_stop || (state == ST_STAB) ||
		(state == ST_SBM_ON) || (state == ST_SBM_OFF);
	wire dev_rst_req = wr_rst && !reg_wdata_in[DEV_RST_BIT] && dev_rst_ok; // [RULE14]
	wire meas_rst_req = wr_rst && !reg_wdata_in[MEAS_RST_BIT] && !dev_rst_req &&
		(in_stop || state == ST_SBM_OFF); // [RULE15]
	wire standby_sel = target_sel[1];
	wire [15:0] cur_mag = cur_sample_in[15] ? (~cur_sample_in + 16'h0001) : cur_sample_in;
	wire cur_above = cur_mag > current_threshold;
	// Either channel's result counts, so the faster one sets the rate
	wire conv_evt = cur_ready_in || volt_ready_in; // [RULE6]
	wire sbm_take = (target_sel == SEL_STANDBY_THRESHOLD_MODE) ? (cur_ready_in && cur_above) : conv_evt;
	wire publish = ((state == ST_NORMAL_FULL_RATE_MODE) && conv_evt) || // [RULE4]
		((state == ST_NORMAL_THRESHOLD_RATE_MODE) && conv_evt && (fast_rate || relax_due)) || // [RULE9]
		((state == ST_SBM_ON) && sbm_take); // [RULE11] [RULE13]
	wire stab_done = (state == ST_STAB) && cyc_exp;
	wire cyc_load = (state == ST_OTP_LOAD) || start_req;
	wire [TMR_W-1:0] cyc_value = (state == ST_OTP_LOAD) ? INIT_CYCLES : STAB_CYCLES;
	wire per_load = (stab_done && target_sel != SEL_NORMAL_FULL_RATE_MODE) ||
		((state == ST_SBM_OFF) && per_exp) || ((state == ST_NORMAL_THRESHOLD_RATE_MODE) && per_exp);
	wire [15:0] per_src = (target_sel == SEL_NORMAL_THRESHOLD_RATE_MODE) ? relaxed_period : standby_period;
	wire [TMR_W-1:0] per_value = {{(TMR_W-16){1'b0}}, per_src};
	wire rd_status = reg_rd_in && (reg_addr_in == ADDR_STATUS);
	wire [1:0] status_set = {publish && volt_ready_in, publish && cur_ready_in};
	wire clk_cfg_wr = reg_wr_in && (reg_addr_in == ADDR_CLK_CFG) &&
		aqs_valid_clk_cfg(reg_wdata_in[2:0]); // [RULE23]
	wire cfg_wr_ok = (state != ST_OTP_LOAD) && (state != ST_RESET);
	wire [7:0] rd_mux =
		(reg_addr_in == ADDR_MODE) ? mode_control :
		(reg_addr_in == ADDR_STATUS) ? {6'h00, status} :
		(reg_addr_in == ADDR_SOFT_RESET) ? SOFT_RESET_READ :
		(reg_addr_in == ADDR_PERIOD_LO) ? standby_period[7:0] :
		(reg_addr_in == ADDR_PERIOD_HI) ? standby_period[15:8] :
		(reg_addr_in == ADDR_THRESH_LO) ? current_threshold[7:0] :
		(reg_addr_in == ADDR_THRESH_HI) ? current_threshold[15:8] :
		(reg_addr_in == ADDR_RELAX_LO) ? relaxed_period[7:0] :
		(reg_addr_in == ADDR_RELAX_HI) ? relaxed_period[15:8] :
		(reg_addr_in == ADDR_CLK_CFG) ? {5'h00, clk_config_out} : 8'h00;

	aqs_timer u_cycle_timer (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.load_in(cyc_load),
		.value_in(cyc_value),
		.tick_in(1'b1),
		.expire_out(cyc_exp)
	);
	// Periods count oscillator edges to keep the counter small
	aqs_timer u_period_timer (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.load_in(per_load),
		.value_in(per_value),
		.tick_in(lp_tick),
		.expire_out(per_exp)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_RESET: begin
				if (digital_power_on_detect_ok && analog_power_on_detect_ok) begin
					next_state = ST_OTP_LOAD; // [RULE24]
				end
			end
			ST_OTP_LOAD: begin
				next_state = ST_INIT;
			end
			ST_INIT: begin
				if (cyc_exp) begin
					next_state = ST_STOP; // [RULE17] [RULE1]
				end
			end
			ST_STOP: begin
				if (start_req) begin
					next_state = ST_STAB; // [RULE19]
				end
			end
			ST_STAB: begin
				if (cyc_exp) begin
					case (target_sel)
						SEL_NORMAL_FULL_RATE_MODE: next_state = ST_NORMAL_FULL_RATE_MODE; // [RULE3]
						SEL_NORMAL_THRESHOLD_RATE_MODE: next_state = ST_NORMAL_THRESHOLD_RATE_MODE; // [RULE8]
						default: next_state = ST_SBM_ON; // [RULE10] [RULE12]
					endcase
				end
			end
			ST_SBM_ON: begin
				if (conv_evt) begin
					next_state = ST_SBM_OFF; // [RULE11]
				end
			end
			ST_SBM_OFF: begin
				if (per_exp) begin
					next_state = ST_SBM_ON;
				end
			end
			default: begin
				next_state = state;
			end
		endcase
		if (stop_req) begin
			next_state = ST_STOP;
		end
		if (dev_rst_req) begin
			next_state = ST_OTP_LOAD; // [RULE14]
		end
		if (!analog_power_on_detect_ok || !digital_power_on_detect_ok) begin
			next_state = ST_RESET; // [RULE24]
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_RESET;
			lp_prev <= 1'b0;
		end else begin
			state <= next_state;
			lp_prev <= lp_level;
		end
	end

	// Defaults reload on every pass through the load state
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			standby_period <= PERIOD_RESET;
			current_threshold <= THRESH_RESET;
			relaxed_period <= RELAX_RESET;
		end else if (state == ST_OTP_LOAD) begin
			standby_period <= PERIOD_RESET;
			current_threshold <= THRESH_RESET;
			relaxed_period <= RELAX_RESET;
		end else if (reg_wr_in && cfg_wr_ok) begin
			case (reg_addr_in)
				ADDR_PERIOD_LO: standby_period[7:0] <= reg_wdata_in;
				ADDR_PERIOD_HI: standby_period[15:8] <= reg_wdata_in;
				ADDR_THRESH_LO: current_threshold[7:0] <= reg_wdata_in;
				ADDR_THRESH_HI: current_threshold[15:8] <= reg_wdata_in;
				ADDR_RELAX_LO: relaxed_period[7:0] <= reg_wdata_in;
				ADDR_RELAX_HI: relaxed_period[15:8] <= reg_wdata_in;
				default: standby_period <= standby_period;
			endcase
		end
	end

	// Mode writes while running only take effect as a stop
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_control <= MODE_RESET;
			target_sel <= SEL_NORMAL_FULL_RATE_MODE;
			clk_config_out <= CLK_CFG_RESET;
		end else if (state == ST_OTP_LOAD) begin
			mode_control <= MODE_RESET;
			target_sel <= SEL_NORMAL_FULL_RATE_MODE;
			clk_config_out <= CLK_CFG_RESET;
		end else begin
			if (wr_mode && (in_stop || stop_req)) begin
				mode_control <= reg_wdata_in;
			end
			if (start_req) begin
				target_sel <= wr_sel;
			end
			if (clk_cfg_wr && cfg_wr_ok) begin
				clk_config_out <= reg_wdata_in[2:0]; // [RULE23]
			end
		end
	end

	// Set wins over the read clear
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			status <= STATUS_RESET;
			reg_rdata_out <= 8'h00;
		end else begin
			status <= (status & ~{2{rd_status}}) | status_set; // [RULE21]
			if (reg_rd_in) begin
				reg_rdata_out <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			fast_rate <= 1'b0;
			relax_due <= 1'b0;
		end else if (state != ST_NORMAL_THRESHOLD_RATE_MODE) begin
			fast_rate <= 1'b0;
			relax_due <= 1'b1;
		end else begin
			if (cur_ready_in) begin
				fast_rate <= cur_above; // [RULE9]
			end
			if (per_exp) begin
				relax_due <= 1'b1;
			end else if (publish) begin
				relax_due <= 1'b0;
			end
		end
	end

	// Published data stays put until the next interrupt
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cur_data_out <= 16'h0000;
			volt_data_out <= 16'h0000;
		end else if (publish) begin
			if (cur_ready_in) begin
				cur_data_out <= cur_sample_in; // [RULE6] [RULE13]
			end
			if (volt_ready_in) begin
				volt_data_out <= volt_sample_in;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_cnt <= 4'h0;
			meas_path_reset_out <= 1'b0;
			datapath_enable_out <= 1'b0;
		end else begin
			if (publish) begin
				int_cnt <= INT_LP_CYCLES; // [RULE5]
			end else if (lp_tick && int_cnt != 4'h0) begin
				int_cnt <= int_cnt - 4'h1;
			end
			meas_path_reset_out <= meas_rst_req || (state == ST_OTP_LOAD); // [RULE15]
			datapath_enable_out <= (next_state == ST_STAB) || (next_state == ST_NORMAL_FULL_RATE_MODE) ||
				(next_state == ST_NORMAL_THRESHOLD_RATE_MODE) || (next_state == ST_SBM_ON); // [RULE1]
		end
	end
	wire int_busy = (int_cnt != 4'h0);
	// Host ignores the init toggling; it is the oscillator itself
	assign int_out = int_busy || ((state == ST_INIT) && lp_level); // [RULE17]

	// Checks
	logic [3:0] lp_seen;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lp_seen <= 4'h0;
		end else if (publish) begin
			lp_seen <= 4'h0;
		end else if (int_busy && lp_tick) begin
			lp_seen <= lp_seen + 4'h1;
		end
	end
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_start_cmd;
		start_req && !dev_rst_req && analog_power_on_detect_ok && digital_power_on_detect_ok;
	endsequence
	sequence s_stab_end;
		(state == ST_STAB) && cyc_exp && !stop_req && !dev_rst_req && analog_power_on_detect_ok && digital_power_on_detect_ok;
	endsequence

	a_start_stab: assert property (s_start_cmd |=> state == ST_STAB) // [RULE2]
		else $error("start did not enter stabilize");
	a_stab_normal_full_rate_mode: assert property (s_stab_end and target_sel == SEL_NORMAL_FULL_RATE_MODE
		|=> state == ST_NORMAL_FULL_RATE_MODE) // [RULE3]
		else $error("stabilize did not reach full rate mode");
	a_stab_normal_threshold_rate_mode: assert property (s_stab_end and target_sel == SEL_NORMAL_THRESHOLD_RATE_MODE
		|=> state == ST_NORMAL_THRESHOLD_RATE_MODE) // [RULE8]
		else $error("stabilize did not reach threshold rate mode");
	a_int_width: assert property ($fell(int_busy) && !publish |-> lp_seen == INT_LP_CYCLES) // [RULE5]
		else $error("interrupt pulse width wrong");
	a_normal_full_rate_mode_int: assert property ((state == ST_NORMAL_FULL_RATE_MODE) && conv_evt |=> int_busy) // [RULE4]
		else $error("no interrupt for new result");
	a_normal_threshold_rate_mode_fast: assert property ((state == ST_NORMAL_THRESHOLD_RATE_MODE) && fast_rate && conv_evt
		|=> int_cnt == INT_LP_CYCLES) // [RULE9]
		else $error("fast rate sample not published");
	a_standby_entry: assert property (!in_stop && (state != ST_STAB) && wr_mode && reg_wdata_in[START_BIT]
		&& $stable(state) |=> state != ST_STAB) // [RULE10]
		else $error("mode started outside stop");
	a_sbm_off: assert property ((state == ST_SBM_ON) && conv_evt && !stop_req
		&& !dev_rst_req && analog_power_on_detect_ok && digital_power_on_detect_ok |=> (state == ST_SBM_OFF) && !datapath_enable_out) // [RULE11]
		else $error("standby did not sleep after sample");
	a_standby_threshold_mode_gate: assert property ((state == ST_SBM_ON) && (target_sel == SEL_STANDBY_THRESHOLD_MODE)
		&& !cur_above |=> $stable(cur_data_out)) // [RULE13]
		else $error("standby data published below threshold");
	a_dev_reset: assert property (dev_rst_req && analog_power_on_detect_ok && digital_power_on_detect_ok
		|=> state == ST_OTP_LOAD ##1 state == ST_INIT) // [RULE14]
		else $error("soft reset did not reinitialise");
	a_meas_reset: assert property ($rose(meas_path_reset_out) |->
		$past(state) inside {ST_STOP, ST_SBM_OFF, ST_OTP_LOAD}) // [RULE15]
		else $error("measurement reset in wrong state");
	a_status_clr: assert property (rd_status && !publish |=> status == 2'h0) // [RULE21]
		else $error("status not cleared by read");
	a_por_loss: assert property (!analog_power_on_detect_ok |=> state == ST_RESET) // [RULE24]
		else $error("analog detector loss ignored");
	a_clk_cfg: assert property (1'b1 |-> aqs_valid_clk_cfg(clk_config_out)) // [RULE23]
		else $error("unsupported clock setting stored");
endmodule

// File: verilog/aqs_pkg.sv
// Constants, types and helpers for the acquisition mode sequencer
// Contract
// RULE1: Rest in stop after power-on, datapath off
// RULE2: Start bit moves stop to first normal mode; the code enters stabilize first
// RULE3: Select bits 00 pick full rate mode
// RULE4: Interrupt per new result in full rate
// RULE5: Interrupt pulse lasts eight oscillator cycles
// RULE6: Faster channel sets rate; data held
// RULE7: Host returns through stop before full rate
// RULE8: Select bits 01 pick threshold rate mode
// RULE9: Above threshold full rate, below relaxed
// RULE10: Standby only from stop; 10 periodic
// RULE11: One sample per standby period, else stop
// RULE12: Select bits 11 pick threshold standby
// RULE13: Standby publish only above threshold
// RULE14: Bit 7 zero soft resets whole device
// RULE15: Bit 6 zero resets measurement path
// RULE16: Host stops external clock during soft reset
// RULE17: 500 us init, interrupt toggles
// RULE18: Host waits for init end
// RULE19: 1.5 ms stabilize before conversions
// RULE20: Host reads within read window
// RULE21: Status clears only when read
// RULE22: Host avoids reads near period end
// RULE23: Only four clock settings accepted
// RULE24: Hold reset until both detectors release
package aqs_pkg;
	localparam int CLK_MHZ = 50;
	localparam int INIT_US = 500;
	localparam int STAB_US = 1500;
	localparam int INIT_CYC = INIT_US * CLK_MHZ;
	localparam int STAB_CYC = STAB_US * CLK_MHZ;
	localparam int TMR_W = 17;
	localparam logic [3:0] INT_LP_CYCLES = 4'h8;
	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h09;
	localparam logic [7:0] ADDR_PERIOD_LO = 8'h0b;
	localparam logic [7:0] ADDR_PERIOD_HI = 8'h0c;
	localparam logic [7:0] ADDR_THRESH_LO = 8'h0d;
	localparam logic [7:0] ADDR_THRESH_HI = 8'h0e;
	localparam logic [7:0] ADDR_RELAX_LO = 8'h0f;
	localparam logic [7:0] ADDR_RELAX_HI = 8'h10;
	localparam logic [7:0] ADDR_CLK_CFG = 8'h11;
	localparam int START_BIT = 0;
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int DEV_RST_BIT = 7;
	localparam int MEAS_RST_BIT = 6;
	localparam logic [1:0] SEL_NORMAL_FULL_RATE_MODE = 2'h0;
	localparam logic [1:0] SEL_NORMAL_THRESHOLD_RATE_MODE = 2'h1;
	localparam logic [1:0] SEL_STANDBY_PERIODIC_MODE = 2'h2;
	localparam logic [1:0] SEL_STANDBY_THRESHOLD_MODE = 2'h3;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] SOFT_RESET_READ = 8'hc0;
	localparam logic [15:0] PERIOD_RESET = 16'h0100;
	localparam logic [15:0] THRESH_RESET = 16'h7fff;
	localparam logic [15:0] RELAX_RESET = 16'h0040;
	localparam logic [2:0] CLK_CFG_RESET = 3'h0;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	typedef enum logic [3:0] {
		ST_RESET, ST_OTP_LOAD, ST_INIT, ST_STOP, ST_STAB,
		ST_NORMAL_FULL_RATE_MODE, ST_NORMAL_THRESHOLD_RATE_MODE, ST_SBM_ON, ST_SBM_OFF
	} aqs_state_type;
	// Bit0 fast modulator, bit1 fast chopper, bit2 decimation 128
	function automatic logic aqs_valid_clk_cfg(input logic [2:0] c);
		return (c == 3'h0) || (c == 3'h1) || (c == 3'h5) || (c == 3'h3);
	endfunction
endpackage

// File: verilog/aqs_timer.sv
// Loadable down counter with expiry pulse
`timescale 1ns/1ps
module aqs_timer
	import aqs_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [TMR_W-1:0] value_in,
	input wire logic tick_in,
	output logic expire_out
);
	logic [TMR_W-1:0] count;
	wire last_tick = tick_in && (count == {{(TMR_W-1){1'b0}}, 1'b1});
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= '0;
		end else if (load_in) begin
			count <= value_in;
		end else if (tick_in && count != '0) begin
			count <= count - 1'b1;
		end
	end
	// Load wins so a reload never reports a stale expiry
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			expire_out <= 1'b0;
		end else begin
			expire_out <= last_tick && !load_in;
		end
	end
endmodule
